/* design/gear_probe_regs.vh */
// Register offsets, field positions, error codes and reset values of the gear/probe checker
`ifndef GEAR_PROBE_REGS_VH
`define GEAR_PROBE_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CMD        12'h000
`define OFF_PARAM      12'h004
`define OFF_AXIS_STAT  12'h008
`define OFF_SPEED      12'h00c
`define OFF_TARGET     12'h010
`define OFF_REACH      12'h014
`define OFF_RESULT     12'h018
`define OFF_STATE      12'h01c

// ----------------------------------------------------------------
// Command codes (CMD register bits 3:0)
// ----------------------------------------------------------------
`define CMD_GEAR_IN    4'h1
`define CMD_GEAR_POS   4'h2
`define CMD_GEAR_OUT   4'h3
`define CMD_PROBE      4'h4

// ----------------------------------------------------------------
// PARAM fields
// ----------------------------------------------------------------
`define P_DEN_LO       0
`define P_DEN_HI       15
`define P_SRC_LO       16
`define P_SRC_HI       17
`define P_MAX_LO       18
`define P_MAX_HI       23
`define P_FOL_LO       24
`define P_FOL_HI       29
`define P_TRIG_LO      30
`define P_TRIG_HI      31

// ----------------------------------------------------------------
// AXIS_STAT bits
// ----------------------------------------------------------------
`define S_MREADY       0
`define S_ENC_MASTER   1
`define S_ENC_PARM_ERR 2
`define S_MTORQUE      3
`define S_MHOMING      4
`define S_PROBE_MAP    5

// ----------------------------------------------------------------
// Limits and error codes
// ----------------------------------------------------------------
`define SRC_MAX        2'd1
`define AX_LO1         6'd1
`define AX_HI1         6'd32
`define AX_LO2         6'd37
`define AX_HI2         6'd42
`define TRIG_MAX       2'd1
`define ERR_NONE       16'h0000
`define ERR_DEN        16'h10d0
`define ERR_SRC        16'h10d1
`define ERR_AXIS       16'h10d2
`define ERR_SAME       16'h10d3
`define ERR_NREADY     16'h10d4
`define ERR_ENC        16'h10d5
`define ERR_TORQUE     16'h10d6
`define ERR_OVSPD      16'h10d7
`define ERR_NOGEAR     16'h10d8
`define ERR_TGTSPD     16'h10d9
`define ERR_REACH      16'h10da
`define ERR_HOMING     16'h10db
`define ERR_PROBE_MAP  16'h10e0
`define ERR_TRIG       16'h10e1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_WORD       32'h0000_0000

`endif

/* design/gear_probe_command_checker.v */
// Gear and touch-probe command checker with APB register access
//
// Functional notes
// - Gear command with ratio denominator zero is refused, code 10D0.
// - Master position source outside legal range refused, code 10D1.
// - Master axis accepted only 1..32 or 37..42, else code 10D2.
// - Master axis equal to follower axis refused, code 10D3.
// - Master axis not ready refuses gear command, code 10D4.
// - Encoder master with encoder parameter error refuses command, code 10D5.
// - Positioned engage refused while master in torque control, code 10D6.
// - Follower speed above limit during gear operation flags code 10D7.
// - Disengage accepted only during gear operation, else code 10D8.
// - Positioned engage target speed below current or gear speed, code 10D9.
// - Synchronous command refused while master is homing, code 10DB.
// - Probe command refused without mapped probe object, code 10E0.
// - Probe trigger select must be 0 or 1, else code 10E1.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "gear_probe_regs.vh"

module gear_probe_command_checker (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Motion status
  output reg         gear_active,
  output reg         probe_armed,
  output reg  [15:0] error_code,
  output reg         cmd_accepted,
  output reg         cmd_rejected
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] param;
  reg [31:0] axis_stat;
  reg [31:0] speed;      // [15:0] follower speed, [31:16] follower limit
  reg [31:0] target;     // [15:0] target speed, [31:16] current/gear speed
  reg [31:0] reach;      // [15:0] follower time needed, [31:16] master time
  reg [3:0]  cmd;
  reg        cmd_go;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire acc    = psel & penable & ~pready;
  wire wr     = acc & pwrite;
  wire mapped = (paddr[11:5] == 7'd0) & (paddr[1:0] == 2'b00);

  // One decoder serves both the write enables and the read-back mux
  function reg_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  wire hit_cmd       = reg_hit(paddr, `OFF_CMD);
  wire hit_param     = reg_hit(paddr, `OFF_PARAM);
  wire hit_axis_stat = reg_hit(paddr, `OFF_AXIS_STAT);
  wire hit_speed     = reg_hit(paddr, `OFF_SPEED);
  wire hit_target    = reg_hit(paddr, `OFF_TARGET);
  wire hit_reach     = reg_hit(paddr, `OFF_REACH);
  wire hit_result    = reg_hit(paddr, `OFF_RESULT);
  wire hit_state     = reg_hit(paddr, `OFF_STATE);

  function axis_ok;
    input [5:0] ax;
    begin
      axis_ok = ((ax >= `AX_LO1) && (ax <= `AX_HI1)) ||
                ((ax >= `AX_LO2) && (ax <= `AX_HI2));
    end
  endfunction

  wire [15:0] den    = param[`P_DEN_HI:`P_DEN_LO];
  wire [1:0]  src    = param[`P_SRC_HI:`P_SRC_LO];
  wire [5:0]  mst    = param[`P_MAX_HI:`P_MAX_LO];
  wire [5:0]  fol    = param[`P_FOL_HI:`P_FOL_LO];
  wire [1:0]  trig   = param[`P_TRIG_HI:`P_TRIG_LO];
  wire        is_pos = (cmd == `CMD_GEAR_POS);

  // ----------------------------------------------------------------
  // Individual checks
  // ----------------------------------------------------------------
  // Each flag is one failure; the chain below picks which one is reported.
  wire f_den    = (den == 16'h0000);
  wire f_src    = (src > `SRC_MAX);
  wire f_axis   = ~axis_ok(mst);
  wire f_same   = (mst == fol);
  wire f_home   = axis_stat[`S_MHOMING];
  wire f_nready = ~axis_stat[`S_MREADY];
  wire f_enc    = axis_stat[`S_ENC_MASTER] & axis_stat[`S_ENC_PARM_ERR];
  wire f_torque = is_pos & axis_stat[`S_MTORQUE];
  wire f_tgtspd = is_pos & (target[15:0] < target[31:16]);
  wire f_reach  = is_pos & (reach[15:0] > reach[31:16]);
  wire f_nogear = ~gear_active;
  wire f_nomap  = ~axis_stat[`S_PROBE_MAP];
  wire f_trig   = (trig > `TRIG_MAX);

  // ----------------------------------------------------------------
  // Check priority: first failing check wins
  // ----------------------------------------------------------------
  reg [15:0] next_err;
  always @* begin
    next_err = `ERR_NONE;
    case (cmd)
      `CMD_GEAR_IN, `CMD_GEAR_POS: begin
        if (f_den)
          next_err = `ERR_DEN;
        else if (f_src)
          next_err = `ERR_SRC;
        else if (f_axis)
          next_err = `ERR_AXIS;
        else if (f_same)
          next_err = `ERR_SAME;
        else if (f_home)
          next_err = `ERR_HOMING;
        else if (f_nready)
          next_err = `ERR_NREADY;
        else if (f_enc)
          next_err = `ERR_ENC;
        else if (f_torque)
          next_err = `ERR_TORQUE;
        else if (f_tgtspd)
          next_err = `ERR_TGTSPD;
        else if (f_reach)
          next_err = `ERR_REACH;
      end
      `CMD_GEAR_OUT: begin
        if (f_nogear)
          next_err = `ERR_NOGEAR;
      end
      `CMD_PROBE: begin
        if (f_nomap)
          next_err = `ERR_PROBE_MAP;
        else if (f_trig)
          next_err = `ERR_TRIG;
      end
      default: next_err = `ERR_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Overspeed monitor
  // ----------------------------------------------------------------
  // Judged every cycle while engaged; the gear stays engaged, only the code moves.
  wire overspeed = gear_active & (speed[15:0] > speed[31:16]);

  // ----------------------------------------------------------------
  // APB handshake
  // ----------------------------------------------------------------
  // Exactly one wait state per access; every answer signal is registered.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // Command register and start strobe
  // ----------------------------------------------------------------
  // The strobe lasts one cycle, so a stale command word is never run twice.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd    <= 4'h0;
      cmd_go <= 1'b0;
    end else begin
      cmd_go <= wr & hit_cmd;
      if (wr && hit_cmd)
        cmd <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Operand registers
  // ----------------------------------------------------------------
  // Operands are plain storage; all but speed (watched every cycle while engaged) are judged only when a command word arrives,
  // so the host may write them in any order beforehand.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      param     <= `RST_WORD;
      axis_stat <= `RST_WORD;
      speed     <= `RST_WORD;
      target    <= `RST_WORD;
      reach     <= `RST_WORD;
    end else begin
      if (wr && hit_param)
        param <= pwdata;
      if (wr && hit_axis_stat)
        axis_stat <= pwdata;
      if (wr && hit_speed)
        speed <= pwdata;
      if (wr && hit_target)
        target <= pwdata;
      if (wr && hit_reach)
        reach <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = `RST_WORD;
    if (hit_cmd)
      next_rdata = {28'h0000000, cmd};
    else if (hit_param)
      next_rdata = param;
    else if (hit_axis_stat)
      next_rdata = axis_stat;
    else if (hit_speed)
      next_rdata = speed;
    else if (hit_target)
      next_rdata = target;
    else if (hit_reach)
      next_rdata = reach;
    else if (hit_result)
      next_rdata = {16'h0000, error_code};
    else if (hit_state)
      next_rdata = {30'h00000000, probe_armed, gear_active};
  end

  // Unmapped reads return zero; a write leaves the last read word alone.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= `RST_WORD;
    else if (acc && !pwrite)
      prdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  // A rejected command touches no motion state; only the code is latched.
  wire accept = cmd_go & (next_err == `ERR_NONE);
  wire reject = cmd_go & (next_err != `ERR_NONE);

  // Outcome pulses last one cycle each
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_accepted <= 1'b0;
      cmd_rejected <= 1'b0;
    end else begin
      cmd_accepted <= accept;
      cmd_rejected <= reject;
    end
  end

  // A command outcome in the same cycle outranks an overspeed report
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      error_code <= `ERR_NONE;
    else if (reject)
      error_code <= next_err;
    else if (accept)
      error_code <= `ERR_NONE;
    else if (overspeed)
      error_code <= `ERR_OVSPD;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_active <= 1'b0;
      probe_armed <= 1'b0;
    end else if (accept) begin
      case (cmd)
        `CMD_GEAR_IN, `CMD_GEAR_POS: gear_active <= 1'b1;
        `CMD_GEAR_OUT:               gear_active <= 1'b0;
        `CMD_PROBE:                  probe_armed <= 1'b1;
        default:                     probe_armed <= probe_armed;
      endcase
    end
  end

endmodule // gear_probe_command_checker

/* test/gp_checker_assertions.sv */
// Checker of APB timing and command outcome relations
`timescale 1ns/1ps
module gp_checker (
  // APB side
  input wire        pclk, presetn, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire        pready, pslverr,
  // Motion status
  input wire        gear_active, probe_armed, cmd_accepted, cmd_rejected,
  input wire [15:0] error_code
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmd_wr; psel && penable && pready && pwrite && paddr == 12'h000; endsequence
  sequence s_done; cmd_accepted || cmd_rejected; endsequence
  a_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_unmapped_err: assert property (pready && paddr > 12'h01c |->
    pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
  a_cmd_answer: assert property (s_cmd_wr |-> ##1 s_done) else $error("no outcome");
  a_rej_hold: assert property (cmd_rejected |-> $stable({gear_active, probe_armed}))
    else $error("state moved on reject");
  a_acc_clear: assert property (cmd_accepted |-> error_code == 16'h0) else $error("code kept");
  a_rej_code: assert property (cmd_rejected |-> error_code != 16'h0) else $error("no code");
  a_one_outcome: assert property (!(cmd_accepted && cmd_rejected)) else $error("both outcomes");
  a_probe_stick: assert property (probe_armed |=> probe_armed) else $error("probe dropped");
endmodule // gp_checker
bind gear_probe_command_checker gp_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .gear_active(gear_active), .probe_armed(probe_armed),
  .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected), .error_code(error_code));

/* test/host_apb.sv */
// Host model: APB master issuing register traffic
`timescale 1ns/1ps
module host_apb (
  // APB master side
  input  wire         pclk,
  output logic        psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input  wire  [31:0] prdata,
  input  wire         pready, pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // Idle bus shows inverted values so a stale word never looks valid
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] rd, output e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // host_apb

/* test/gear_probe_command_checker_tb.sv */
// Self-checking bench for the gear and probe command checker
`timescale 1ns/1ps
module gear_probe_command_checker_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic gear_active, probe_armed, cmd_accepted, cmd_rejected;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] error_code;
  logic [5:0]  bad [5] = '{6'h00, 6'h21, 6'h24, 6'h2b, 6'h3f};
  logic [5:0]  good [4] = '{6'h01, 6'h20, 6'h25, 6'h2a};
  int n_fail, n_checks, cyc;
  localparam logic [31:0] G = 32'h0204_0001;
  host_apb i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  gear_probe_command_checker i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gear_active(gear_active), .probe_armed(probe_armed),
    .error_code(error_code), .cmd_accepted(cmd_accepted), .cmd_rejected(cmd_rejected));
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  function logic [31:0] pm(input [1:0] t, input [5:0] m, input [1:0] s, input [15:0] d);
    pm = {t, 6'h02, m, s, d};
  endfunction
  task chk(input [31:0] x, input [31:0] g, input string nm);
    n_checks++;
    if (g !== x) begin
      $display("[ERR] %s exp %h got %h", nm, x, g);
      n_fail++;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    i_host.xfer(1'h1, a, d, rd, e);
  endtask
  task rdc(input [11:0] a, input [31:0] x, input xe, input string nm);
    i_host.xfer(1'h0, a, 32'h0, rd, e);
    chk(x, rd, nm);
    chk({31'h0, xe}, {31'h0, e}, "pslverr");
  endtask
  // Operands first, command word last, then judge code and state
  task cmd(input [3:0] c, input [31:0] p, input [5:0] s, input [31:0] tg, input [31:0] rc,
           input [15:0] ec, input [1:0] st);
    wr(12'h004, p);
    wr(12'h008, {26'h0, s});
    wr(12'h010, tg);
    wr(12'h014, rc);
    wr(12'h000, {28'h0, c});
    @(negedge pclk);
    chk({30'h0, ec != 16'h0, ec == 16'h0}, {30'h0, cmd_rejected, cmd_accepted}, "outcome");
    repeat (3) @(posedge pclk);
    chk({16'h0, ec}, {16'h0, error_code}, "error_code");
    chk({30'h0, st}, {30'h0, probe_armed, gear_active}, "state");
  endtask
  task t_regs;
    rdc(12'h018, 32'h0, 1'h0, "result");
    rdc(12'h01c, 32'h0, 1'h0, "state_reg");
    rdc(12'h020, 32'h0, 1'h1, "unmapped");
    wr(12'h018, 32'hffff);
    rdc(12'h018, 32'h0, 1'h0, "ro_result");
    wr(12'h00c, 32'hffff_0000);
    $display("t_regs done");
  endtask
  task t_gear_err;
    cmd(4'h1, pm(2'h0, 6'h01, 2'h0, 16'h0), 6'h01, 0, 0, 16'h10d0, 2'h0);
    cmd(4'h1, pm(2'h0, 6'h01, 2'h2, 16'h1), 6'h01, 0, 0, 16'h10d1, 2'h0);
    foreach (bad[i]) cmd(4'h1, pm(2'h0, bad[i], 2'h0, 16'h1), 6'h01, 0, 0, 16'h10d2, 2'h0);
    cmd(4'h1, pm(2'h0, 6'h02, 2'h0, 16'h1), 6'h01, 0, 0, 16'h10d3, 2'h0);
    cmd(4'h1, G, 6'h11, 0, 0, 16'h10db, 2'h0);
    cmd(4'h1, G, 6'h00, 0, 0, 16'h10d4, 2'h0);
    cmd(4'h1, G, 6'h07, 0, 0, 16'h10d5, 2'h0);
    cmd(4'h2, G, 6'h09, 0, 0, 16'h10d6, 2'h0);
    cmd(4'h2, G, 6'h01, 32'h0064_0032, 0, 16'h10d9, 2'h0);
    cmd(4'h2, G, 6'h01, 0, 32'h000a_000b, 16'h10da, 2'h0);
    cmd(4'h3, G, 6'h01, 0, 0, 16'h10d8, 2'h0);
    $display("t_gear_err done");
  endtask
  task t_gear_ok;
    foreach (good[i]) begin
      cmd(4'h1, pm(2'h0, good[i], 2'h0, 16'h1), 6'h01, 0, 0, 16'h0, 2'h1);
      cmd(4'h3, G, 6'h01, 0, 0, 16'h0, 2'h0);
    end
    cmd(4'h2, G, 6'h01, 32'h0032_0032, 32'h000a_000a, 16'h0, 2'h1);
    cmd(4'h1, pm(2'h0, 6'h01, 2'h0, 16'h0), 6'h01, 0, 0, 16'h10d0, 2'h1);
    wr(12'h00c, 32'h000a_000b);
    repeat (3) @(posedge pclk);
    chk(32'h10d7, {16'h0, error_code}, "overspeed");
    chk(32'h1, {31'h0, gear_active}, "gear_kept");
    wr(12'h00c, 32'hffff_0000);
    cmd(4'h3, G, 6'h01, 0, 0, 16'h0, 2'h0);
    $display("t_gear_ok done");
  endtask
  task t_probe;
    cmd(4'h4, G, 6'h01, 0, 0, 16'h10e0, 2'h0);
    cmd(4'h4, pm(2'h2, 6'h01, 2'h0, 16'h1), 6'h21, 0, 0, 16'h10e1, 2'h0);
    cmd(4'h4, pm(2'h0, 6'h01, 2'h0, 16'h1), 6'h21, 0, 0, 16'h0, 2'h2);
    cmd(4'h4, pm(2'h1, 6'h01, 2'h0, 16'h1), 6'h21, 0, 0, 16'h0, 2'h2);
    $display("t_probe done");
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    presetn = 1'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_gear_err;
    t_gear_ok;
    t_probe;
    end_of_test;
  end
endmodule // gear_probe_command_checker_tb
